/* File: common/irq_route_map.vh */
// constants for the pci interrupt router: legacy irq numbering and steering codes
// assumes inclusion by bare name from design files; no logic here
`ifndef IRQ_ROUTE_MAP_VH
`define IRQ_ROUTE_MAP_VH

// =====================================================
// widths
`define NUM_LINES      3'h4
`define SEL_W          3
`define IRQ_W          16

// =====================================================
// steering select codes, one per legal legacy irq
`define SEL_IRQ3       3'h0
`define SEL_IRQ4       3'h1
`define SEL_IRQ5       3'h2
`define SEL_IRQ7       3'h3
`define SEL_IRQ9       3'h4
`define SEL_IRQ11      3'h5
`define SEL_IRQ14      3'h6
`define SEL_IRQ15      3'h7

// =====================================================
// legacy irq bit positions
`define IRQ3_BIT       3
`define IRQ4_BIT       4
`define IRQ5_BIT       5
`define IRQ7_BIT       7
`define IRQ9_BIT       9
`define IRQ11_BIT      11
`define IRQ13_BIT      13
`define IRQ14_BIT      14
`define IRQ15_BIT      15

// =====================================================
// reset values
`define LINE_EN_RST    1'h0
`define LINE_SEL_RST   3'h0
`define SYNC_RST       6'h3F
`define ROUTE_RST      1'h0
`define LEGACY_RST     16'h0000

// =====================================================
// level of an unused line input: inactive high
`define SRC_IDLE_N     1'h1

`endif

/* File: src/line_steer.v */
// one routable request line: sync, wire-join and steering onto a one-hot legacy irq vector
// assumes source pins are asynchronous active-low levels
`timescale 1ns/10ps
`include "irq_route_map.vh"

module line_steer
(
  input  wire                clk,       // system clock
  input  wire                reset_n,   // async reset, active low
  input  wire [5:0]          src_n,     // joined sources, active low
  input  wire                enable,    // steering enabled
  input  wire [`SEL_W-1:0]   sel,       // steering select code
  output wire                active,    // synchronised shared request
  output reg  [`IRQ_W-1:0]   irq_vec    // one-hot contribution to legacy irqs
);

  reg  [5:0] meta_r;
  reg  [5:0] sync_r;
  reg  [`IRQ_W-1:0] vec_nxt;

  // =====================================================
  // synchroniser
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= `SYNC_RST;
      sync_r <= `SYNC_RST;
    end
    else
    begin
      meta_r <= src_n;
      sync_r <= meta_r;
    end
  end

  // inverted wired-and of open-drain sources: high while any source asks
  assign active = ~&sync_r;

  // =====================================================
  // steering decode
  always @*
  begin
    vec_nxt = {`IRQ_W{1'b0}};
    if (active && enable)
    begin
      case (sel)
        `SEL_IRQ3:  vec_nxt[`IRQ3_BIT]  = 1'b1;
        `SEL_IRQ4:  vec_nxt[`IRQ4_BIT]  = 1'b1;
        `SEL_IRQ5:  vec_nxt[`IRQ5_BIT]  = 1'b1;
        `SEL_IRQ7:  vec_nxt[`IRQ7_BIT]  = 1'b1;
        `SEL_IRQ9:  vec_nxt[`IRQ9_BIT]  = 1'b1;
        `SEL_IRQ11: vec_nxt[`IRQ11_BIT] = 1'b1;
        `SEL_IRQ14: vec_nxt[`IRQ14_BIT] = 1'b1;
        `SEL_IRQ15: vec_nxt[`IRQ15_BIT] = 1'b1;
        default:    vec_nxt = {`IRQ_W{1'b0}};
      endcase
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_vec <= {`IRQ_W{1'b0}};
    else
      irq_vec <= vec_nxt;
  end

endmodule // line_steer

/* File: src/pci_interrupt_router.v */
// top of the pci interrupt router: slot and onboard sources onto four lines, lines onto legacy irqs
// assumes steering settings are static levels from firmware config logic on clk
`timescale 1ns/10ps
`include "irq_route_map.vh"

module pci_interrupt_router
(
  input  wire                clk,            // system clock 25 MHz
  input  wire                reset_n,        // async reset, active low
  input  wire [3:0]          slot1_int_n,    // slot 1 inta..intd (bit0 = inta), active low
  input  wire [3:0]          slot2_int_n,    // slot 2 inta..intd, active low
  input  wire [3:0]          slot3_int_n,    // slot 3 inta..intd, active low
  input  wire                usb_int_n,      // onboard usb request, active low
  input  wire                video_int_n,    // onboard video request, active low
  input  wire                enet_int_n,     // onboard ethernet request, active low
  input  wire [3:0]          line_enable,    // per line steering enable (a..d)
  input  wire [`SEL_W-1:0]   sel_line_a,     // steering code line a
  input  wire [`SEL_W-1:0]   sel_line_b,     // steering code line b
  input  wire [`SEL_W-1:0]   sel_line_c,     // steering code line c
  input  wire [`SEL_W-1:0]   sel_line_d,     // steering code line d
  output reg                 route_line_a,   // line a active (high = request)
  output reg                 route_line_b,   // line b active
  output reg                 route_line_c,   // line c active
  output reg                 route_line_d,   // line d active
  output reg  [`IRQ_W-1:0]   legacy_irq      // legacy irq levels, high = request
);

  // =====================================================
  // timing and limits
  // a pin level reaches route_line_x after three edges (two sync flops and the
  // output flop) and legacy_irq after four, because the steering decode inside
  // each line is registered before the merge.
  // a steering change shows on legacy_irq after two edges; firmware should hold a
  // line's enable low while it rewrites that line's select code, or one stray
  // cycle on the old irq may follow.
  // there is no edge capture: a source that never releases keeps its irq busy,
  // which is what level-shared lines rely on.

  // =====================================================
  // slot 1 pins; bit 0 of each slot bus is inta
  wire              slot1_inta_n;
  wire              slot1_intb_n;
  wire              slot1_intc_n;
  wire              slot1_intd_n;

  assign slot1_inta_n = slot1_int_n[0];
  assign slot1_intb_n = slot1_int_n[1];
  assign slot1_intc_n = slot1_int_n[2];
  assign slot1_intd_n = slot1_int_n[3];

  // =====================================================
  // slot 2 pins
  wire              slot2_inta_n;
  wire              slot2_intb_n;
  wire              slot2_intc_n;
  wire              slot2_intd_n;

  assign slot2_inta_n = slot2_int_n[0];
  assign slot2_intb_n = slot2_int_n[1];
  assign slot2_intc_n = slot2_int_n[2];
  assign slot2_intd_n = slot2_int_n[3];

  // =====================================================
  // slot 3 pins
  wire              slot3_inta_n;
  wire              slot3_intb_n;
  wire              slot3_intc_n;
  wire              slot3_intd_n;

  assign slot3_inta_n = slot3_int_n[0];
  assign slot3_intb_n = slot3_int_n[1];
  assign slot3_intc_n = slot3_int_n[2];
  assign slot3_intd_n = slot3_int_n[3];

  // =====================================================
  // per-line joined sources and shared request levels
  wire [5:0]        src_a_n;
  wire [5:0]        src_b_n;
  wire [5:0]        src_c_n;
  wire [5:0]        src_d_n;
  wire              act_a;
  wire              act_b;
  wire              act_c;
  wire              act_d;

  // =====================================================
  // steering vectors
  wire [`IRQ_W-1:0] vec_a;
  wire [`IRQ_W-1:0] vec_b;
  wire [`IRQ_W-1:0] vec_c;
  wire [`IRQ_W-1:0] vec_d;
  wire [`IRQ_W-1:0] legacy_nxt;

  // =====================================================
  // line a: slot 1 intc, slot 2 inta, slot 3 intb
  assign src_a_n[0] = slot1_intc_n;
  assign src_a_n[1] = slot2_inta_n;
  assign src_a_n[2] = slot3_intb_n;
  assign src_a_n[3] = `SRC_IDLE_N;
  assign src_a_n[4] = `SRC_IDLE_N;
  assign src_a_n[5] = `SRC_IDLE_N;

  line_steer u_line_a
  (
    .clk     (clk),
    .reset_n (reset_n),
    .src_n   (src_a_n),
    .enable  (line_enable[0]),
    .sel     (sel_line_a),
    .active  (act_a),
    .irq_vec (vec_a)
  );

  // =====================================================
  // line b: slot 1 intb, slot 2 intc, slot 3 inta
  assign src_b_n[0] = slot1_intb_n;
  assign src_b_n[1] = slot2_intc_n;
  assign src_b_n[2] = slot3_inta_n;
  assign src_b_n[3] = `SRC_IDLE_N;
  assign src_b_n[4] = `SRC_IDLE_N;
  assign src_b_n[5] = `SRC_IDLE_N;

  line_steer u_line_b
  (
    .clk     (clk),
    .reset_n (reset_n),
    .src_n   (src_b_n),
    .enable  (line_enable[1]),
    .sel     (sel_line_b),
    .active  (act_b),
    .irq_vec (vec_b)
  );

  // =====================================================
  // line c: slot 1 inta, slot 2 intb, slot 3 intc
  // plus the onboard ethernet controller
  assign src_c_n[0] = slot1_inta_n;
  assign src_c_n[1] = slot2_intb_n;
  assign src_c_n[2] = slot3_intc_n;
  assign src_c_n[3] = enet_int_n;
  assign src_c_n[4] = `SRC_IDLE_N;
  assign src_c_n[5] = `SRC_IDLE_N;

  line_steer u_line_c
  (
    .clk     (clk),
    .reset_n (reset_n),
    .src_n   (src_c_n),
    .enable  (line_enable[2]),
    .sel     (sel_line_c),
    .active  (act_c),
    .irq_vec (vec_c)
  );

  // =====================================================
  // line d: intd of every slot
  // plus the onboard usb and video controllers
  assign src_d_n[0] = slot1_intd_n;
  assign src_d_n[1] = slot2_intd_n;
  assign src_d_n[2] = slot3_intd_n;
  assign src_d_n[3] = usb_int_n;
  assign src_d_n[4] = video_int_n;
  assign src_d_n[5] = `SRC_IDLE_N;

  line_steer u_line_d
  (
    .clk     (clk),
    .reset_n (reset_n),
    .src_n   (src_d_n),
    .enable  (line_enable[3]),
    .sel     (sel_line_d),
    .active  (act_d),
    .irq_vec (vec_d)
  );

  // =====================================================
  // lines steered to one irq simply or together; firmware decides whether they share
  assign legacy_nxt = vec_a | vec_b | vec_c | vec_d;

  // =====================================================
  // route line registers: every port leaves from a flop
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      route_line_a <= `ROUTE_RST;
    else
      route_line_a <= act_a;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      route_line_b <= `ROUTE_RST;
    else
      route_line_b <= act_b;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      route_line_c <= `ROUTE_RST;
    else
      route_line_c <= act_c;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      route_line_d <= `ROUTE_RST;
    else
      route_line_d <= act_d;
  end

  // =====================================================
  // legacy irq register
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      legacy_irq <= `LEGACY_RST;
    else
      legacy_irq <= legacy_nxt;
  end

endmodule // pci_interrupt_router

/* File: tb/pci_src_model.sv */
// far side: pci interrupt sources as active-low levels
// assumes req bits 0-11 are slot 1-3 pins a-d, then usb, video, ethernet
`timescale 1ns/10ps
module pci_src_model
(
  input  wire logic [14:0] req,         // high = source asks
  output wire logic [3:0]  slot1_int_n, // slot 1 pins
  output wire logic [3:0]  slot2_int_n, // slot 2 pins
  output wire logic [3:0]  slot3_int_n, // slot 3 pins
  output wire logic        usb_int_n,   // onboard usb
  output wire logic        video_int_n, // onboard video
  output wire logic        enet_int_n   // onboard ethernet
);
  // ====================
  // held as a level for as long as the request stands
  assign {enet_int_n, video_int_n, usb_int_n, slot3_int_n, slot2_int_n, slot1_int_n} = ~req;
endmodule // pci_src_model

/* File: tb/pci_interrupt_router_chk.sv */
// assertions on the router ports
// assumes steering inputs stay still while a line is active
`timescale 1ns/10ps
`include "irq_route_map.vh"
module pci_interrupt_router_chk
(
  input wire logic               clk,          // clock
  input wire logic               reset_n,      // reset, active low
  input wire logic               usb_int_n,    // onboard usb
  input wire logic               video_int_n,  // onboard video
  input wire logic               enet_int_n,   // onboard ethernet
  input wire logic [3:0]         slot1_int_n,  // slot 1 pins
  input wire logic [3:0]         slot2_int_n,  // slot 2 pins
  input wire logic [3:0]         slot3_int_n,  // slot 3 pins
  input wire logic [3:0]         line_enable,  // steering enables
  input wire logic [`SEL_W-1:0]  sel_line_a,   // code line a
  input wire logic [`SEL_W-1:0]  sel_line_b,   // code line b
  input wire logic [`SEL_W-1:0]  sel_line_c,   // code line c
  input wire logic [`SEL_W-1:0]  sel_line_d,   // code line d
  input wire logic               route_line_a, // line a
  input wire logic               route_line_b, // line b
  input wire logic               route_line_c, // line c
  input wire logic               route_line_d, // line d
  input wire logic [`IRQ_W-1:0]  legacy_irq    // legacy irqs
);
  // ====================
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [`IRQ_W-1:0] exp_r;
  function automatic logic [`IRQ_W-1:0] hot(input logic on, input logic [2:0] s);
    logic [3:0] n [8];
    n = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hB, 4'hE, 4'hF};
    return on ? 16'h0001 << n[s] : 16'h0000;
  endfunction
  always @(posedge clk or negedge reset_n)
    if (!reset_n) exp_r <= 16'h0000;
    else exp_r <= hot(route_line_a & line_enable[0], sel_line_a) | hot(route_line_b & line_enable[1], sel_line_b)
      | hot(route_line_c & line_enable[2], sel_line_c) | hot(route_line_d & line_enable[3], sel_line_d);
  a_line_a_join: assert property (route_line_a == !$past(&{slot1_int_n[2], slot2_int_n[0], slot3_int_n[1]}, 3))
    else $error("line a wrong");
  a_line_b_join: assert property (route_line_b == !$past(&{slot1_int_n[1], slot2_int_n[2], slot3_int_n[0]}, 3))
    else $error("line b wrong");
  a_line_c_join: assert property (route_line_c == !$past(&{slot1_int_n[0], slot2_int_n[1], slot3_int_n[2], enet_int_n}, 3))
    else $error("line c wrong");
  a_line_d_join: assert property (route_line_d == !$past(&{slot1_int_n[3], slot2_int_n[3], slot3_int_n[3], usb_int_n, video_int_n}, 3))
    else $error("line d wrong");
  a_legacy_steer: assert property (legacy_irq == exp_r)
    else $error("legacy irq wrong");
  a_legal_irqs: assert property ((legacy_irq & 16'h3547) == 16'h0000)
    else $error("illegal irq set");
  a_reserved_quiet: assert property ((legacy_irq & 16'h3400) == 16'h0000)
    else $error("reserved irq set");
  a_enet_latency: assert property ($fell(enet_int_n) |-> ##3 route_line_c)
    else $error("ethernet late");
  a_reset_quiet: assert property ($rose(reset_n) |-> legacy_irq == 16'h0000 && !route_line_d)
    else $error("active after reset");
  c_all_lines: cover property (route_line_a && route_line_b && route_line_c && route_line_d);
  c_top_irq: cover property (legacy_irq[15]);
  c_refused: cover property (route_line_a && !line_enable[0]);
endmodule // pci_interrupt_router_chk
bind pci_interrupt_router pci_interrupt_router_chk chk
(
  .clk          (clk),
  .reset_n      (reset_n),
  .usb_int_n    (usb_int_n),
  .video_int_n  (video_int_n),
  .enet_int_n   (enet_int_n),
  .slot1_int_n  (slot1_int_n),
  .slot2_int_n  (slot2_int_n),
  .slot3_int_n  (slot3_int_n),
  .line_enable  (line_enable),
  .sel_line_a   (sel_line_a),
  .sel_line_b   (sel_line_b),
  .sel_line_c   (sel_line_c),
  .sel_line_d   (sel_line_d),
  .route_line_a (route_line_a),
  .route_line_b (route_line_b),
  .route_line_c (route_line_c),
  .route_line_d (route_line_d),
  .legacy_irq   (legacy_irq)
);

/* File: tb/tb_pci_interrupt_router.sv */
// self-checking bench for the router
// assumes source model and checker compiled alongside
`timescale 1ns/10ps
module tb_pci_interrupt_router;
  // ====================
  logic clk = 1'b0, reset_n = 1'b0, usb_int_n, video_int_n, enet_int_n;
  logic route_line_a, route_line_b, route_line_c, route_line_d;
  logic [3:0] slot1_int_n, slot2_int_n, slot3_int_n, line_enable = 4'hF;
  logic [2:0] sel_line_a = 3'h7, sel_line_b = 3'h5, sel_line_c = 3'h2, sel_line_d = 3'h0;
  logic [15:0] legacy_irq;
  logic [14:0] req = 15'h0000;
  int miscompares = 0, checked = 0, cycles = 0;
  logic [1:0] map [12] = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h0, 2'h2, 2'h1, 2'h3, 2'h1, 2'h0, 2'h2, 2'h3};
  logic [3:0] num [8] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hB, 4'hE, 4'hF};
  logic [3:0] lirq [4] = '{4'hF, 4'hB, 4'h5, 4'h3};
  wire [3:0] lines = {route_line_d, route_line_c, route_line_b, route_line_a};
  pci_src_model src
  (
    .req         (req),
    .slot1_int_n (slot1_int_n),
    .slot2_int_n (slot2_int_n),
    .slot3_int_n (slot3_int_n),
    .usb_int_n   (usb_int_n),
    .video_int_n (video_int_n),
    .enet_int_n  (enet_int_n)
  );
  pci_interrupt_router uut
  (
    .clk          (clk),
    .reset_n      (reset_n),
    .slot1_int_n  (slot1_int_n),
    .slot2_int_n  (slot2_int_n),
    .slot3_int_n  (slot3_int_n),
    .usb_int_n    (usb_int_n),
    .video_int_n  (video_int_n),
    .enet_int_n   (enet_int_n),
    .line_enable  (line_enable),
    .sel_line_a   (sel_line_a),
    .sel_line_b   (sel_line_b),
    .sel_line_c   (sel_line_c),
    .sel_line_d   (sel_line_d),
    .route_line_a (route_line_a),
    .route_line_b (route_line_b),
    .route_line_c (route_line_c),
    .route_line_d (route_line_d),
    .legacy_irq   (legacy_irq)
  );
  initial forever #20 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // ====================
  // five cycles covers the three-edge sync path plus the legacy stage
  task settle(input logic [14:0] r);
    req = r;
    repeat (5) @(negedge clk);
  endtask
  task t_slot_map;
    for (int i = 0; i < 12; i++)
    begin
      settle(15'h0001 << i);
      check(lines, 4'h1 << map[i]);
      check(legacy_irq, 16'h0001 << lirq[map[i]]);
      settle(15'h0000);
    end
  endtask
  task t_onboard;
    settle(15'h1000);
    check(lines, 4'h8);
    settle(15'h3000);
    settle(15'h2000);
    check(lines, 4'h8);
    settle(15'h4000);
    check(lines, 4'h4);
    settle(15'h0000);
    check(lines, 4'h0);
  endtask
  task t_enable_off;
    line_enable = 4'hE;
    settle(15'h0010);
    check(lines, 4'h1);
    check(legacy_irq, 16'h0000);
    settle(15'h0000);
    line_enable = 4'hF;
  endtask
  task t_share;
    for (int k = 0; k < 8; k++)
    begin
      {sel_line_a, sel_line_b, sel_line_c, sel_line_d} = {4{k[2:0]}};
      settle(15'h000F);
      check(legacy_irq, 16'h0001 << num[k]);
      settle(15'h0000);
    end
  endtask
  task end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check(legacy_irq, 16'h0000);
    t_slot_map;
    t_onboard;
    t_enable_off;
    t_share;
    end_of_test();
  end
endmodule // tb_pci_interrupt_router
